// ---- bench/excitation_mode_watchdog_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module excitation_mode_watchdog_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic        sample_tick = 1'b0;
	logic        link_up = 1'b1;
	logic        stall = 1'b0;
	logic [31:0] reg_rdata;
	logic        reg_rdata_valid, out_valid, out_ready, in_ready, got;
	logic [15:0] out_sample;
	logic [1:0]  out_target;
	logic [17:0] q[$];
	int          errors = 0;
	int          n_tests = 0;
	always #12.5 clk = !clk;
	excitation_mode_watchdog #(.SAMPLES_PER_MS(16'h2)) excitation_mode_watchdog_inst (.*);
	loop_model loop_model_inst (.*);
	always @(posedge clk) if (got) q.push_back({out_target, out_sample});
	// ----
	// Tasks
	// ----
	task automatic chk(input string name, input logic [32:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk("rdata", {reg_rdata_valid, reg_rdata}, {1'b1, e});
		@(posedge clk);
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, e);
		wr(a, d);
		rd(a, e);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			sample_tick <= 1'b1;
			@(posedge clk);
			sample_tick <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	task automatic run(input logic [31:0] p, m);
		wr(8'h2c, p);
		wr(8'h2e, m);
		q.delete();
		tick(32);
		repeat (4) @(posedge clk);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		rd(8'h2e, 32'h0);
		rd(8'h30, 32'h0);
		rd(8'h32, 32'h13);
		wr_rd(8'h2c, 32'h3, 32'h0);
		wr_rd(8'h2e, 32'h5, 32'h0);
		wr_rd(8'h2e, 32'h1_0001, 32'h0);
		wr_rd(8'h30, 32'h1000_0001, 32'h0);
		wr_rd(8'h30, 32'h1000_0000, 32'h1000_0000);
		wr_rd(8'h32, 32'h3, 32'h13);
		wr_rd(8'h32, 32'h14, 32'h13);
		wr_rd(8'h32, 32'h4, 32'h4);
		wr_rd(8'h40, 32'h7, 32'h0);
		for (int i = 0; i < 3; i++) wr_rd(8'h2c, 32'(i), 32'(i));
		for (int i = 0; i < 5; i++) wr_rd(8'h2e, 32'(i), 32'(i));
	endtask
	task automatic t_watchdog();
		wr(8'h30, 32'h0);
		wr(8'h2e, 32'h1);
		tick(20);
		rd(8'h2e, 32'h1);
		wr(8'h30, 32'h2);
		wr(8'h2e, 32'h1);
		tick(3);
		wr(8'h2e, 32'h2);
		tick(3);
		rd(8'h2e, 32'h2);
		tick(1);
		rd(8'h2e, 32'h0);
		wr(8'h30, 32'h0);
		wr(8'h2e, 32'h3);
		link_up <= 1'b0;
		wr_rd(8'h2e, 32'h1, 32'h0);
		link_up <= 1'b1;
	endtask
	task automatic t_stream();
		logic signed [15:0] s;
		logic signed [15:0] pk;
		wr(8'h36, 32'h64);
		wr(8'h38, 32'h32);
		for (int p = 1; p < 3; p++) begin
			for (int m = 1; m < 5; m++) begin
				run(32'(p), 32'(m));
				chk("count", 33'(q.size()), 33'(32));
				pk = (m == 4 || p == 1) ? 16'sh64 : 16'sh32;
				for (int i = 0; i < 32; i++) begin
					s = q[i][15:0];
					chk("target", 33'(q[i][17:16]), 33'(p));
					if (m == 1) chk("binary", 33'(s == pk || s == -pk), 33'(1));
					if (m == 1 && i < 16) chk("repeat", 33'(q[i]), 33'(q[i + 16]));
					if (m == 3) chk("noise", 33'(s >= -pk && s <= pk), 33'(1));
					if (m == 4) chk("offset", 33'(s), 33'(pk));
				end
			end
		end
	endtask
	task automatic t_full();
		q.delete();
		stall <= 1'b1;
		tick(3);
		#1 chk("in_ready", 33'(in_ready), 33'(0));
		stall <= 1'b0;
		repeat (8) @(posedge clk);
		#1 chk("drained", 33'(q.size()), 33'(2));
	endtask
	task automatic finish_test();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_watchdog();
		t_stream();
		t_full();
		finish_test();
	end
	// Roughly thirty times the expected run
	initial begin
		#1_000_000;
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire

// ---- bench/excitation_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module excitation_properties #(
	parameter [15:0] SAMPLES_PER_MS = 16'h0010
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_rdata_valid,
	input wire logic        sample_tick,
	input wire logic        link_up,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [15:0] out_sample,
	input wire logic [1:0]  out_target,
	input wire logic        in_ready
);
	// ----
	// Properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence link_lost_read;
		!link_up ##1 (!link_up && reg_read && reg_addr == 8'h2e);
	endsequence
	sequence held;
		out_valid && !out_ready;
	endsequence
	a_read_answered: assert property (reg_read |=> reg_rdata_valid)
		else $error("read not answered");
	a_link_forces_off: assert property (link_lost_read |=> reg_rdata == 32'h0)
		else $error("mode alive without link");
	a_idle_point_zero: assert property (out_valid && out_target == 2'h0 |-> out_sample == 16'h0)
		else $error("sample without injection point");
	a_target_legal: assert property (out_valid |-> out_target <= 2'h2)
		else $error("bad target");
	a_sample_held: assert property (held |=> out_valid && $stable(out_sample) && $stable(out_target))
		else $error("stalled sample changed");
	a_push_visible: assert property (sample_tick && in_ready |=> out_valid)
		else $error("pushed sample missing");
	a_full_not_empty: assert property (!in_ready |-> out_valid)
		else $error("full yet empty");
	a_mode_range: assert property (reg_read && reg_addr == 8'h2e |=> reg_rdata <= 32'h4)
		else $error("mode out of range");
	a_period_range: assert property (reg_read && reg_addr == 8'h30 |=> reg_rdata <= 32'h1000_0000)
		else $error("period out of range");
	a_depth_range: assert property (reg_read && reg_addr == 8'h32 |=> reg_rdata inside {[32'h4:32'h13]})
		else $error("depth out of range");
endmodule
bind excitation_mode_watchdog excitation_properties #(.SAMPLES_PER_MS(SAMPLES_PER_MS)) props_inst (.*);
`default_nettype wire

// ---- bench/loop_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module loop_model (
	// Stream side
	input  wire logic clk,
	input  wire logic out_valid,
	output wire logic out_ready,
	// Test side
	input  wire logic stall,
	output wire logic got
);
	// ----
	// Ready pacing
	// ----
	logic ph = 1'b0;
	// Takes one word every other cycle; the buffer fills only while stall is held
	always @(posedge clk) ph <= !ph;
	assign out_ready = ph && !stall;
	assign got = out_valid && out_ready;
endmodule
`default_nettype wire

// ---- rtl/excitation_defines.vh ----
// Functional notes
// [R1] Injection point: 0 none, 1 current loop, 2 velocity loop.
// [R2] Waveform mode 0..4: off, pseudo-random binary, sine, noise, constant offset.
// [R3] Lost host link forces waveform mode to off.
// [R4] Peak amplitude is current amplitude for current loop, velocity amplitude otherwise.
// [R5] Watchdog period zero leaves the mode alone forever.
// [R6] Nonzero period clears mode after that many milliseconds since timer start.
// [R7] Nonzero mode rewrite restarts watchdog; host must repeat it each period.
// [R8] Pseudo-random binary samples are always plus or minus the peak amplitude.
// [R9] Binary sequence repeats after two to the depth over the sample gap samples.
// [R10] Noise mode outputs random values between minus and plus peak amplitude.
// [R11] Offset mode outputs a constant equal to the current amplitude.
// [R12] Watchdog period in ms, range 0 to 268,435,456, reset value zero.
// [R13] Sequence depth accepts 4 through 19, reset value 19.
// [R14] Out-of-range mode or injection point writes are ignored.
// [R15] One sample per drive sample period; millisecond tick derived from that clock.
`ifndef EXCITATION_DEFINES_VH
`define EXCITATION_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_INJECTION_POINT 8'h2c
`define OFS_WAVEFORM_MODE   8'h2e
`define OFS_WATCHDOG_PERIOD 8'h30
`define OFS_SEQ_DEPTH       8'h32
`define OFS_SAMPLE_GAP      8'h34
`define OFS_CURRENT_AMP     8'h36
`define OFS_VELOCITY_AMP    8'h38

// ----------------------------------------------------------------
// Encodings and limits
// ----------------------------------------------------------------
`define POINT_NONE     2'h0
`define POINT_CURRENT  2'h1
`define POINT_VELOCITY 2'h2
`define MODE_OFF       3'h0
`define MODE_BINARY    3'h1
`define MODE_SINE      3'h2
`define MODE_NOISE     3'h3
`define MODE_OFFSET    3'h4
`define PERIOD_MAX     32'h1000_0000
`define PERIOD_RESET   32'h0000_0000
`define AMP_RESET      15'h0000
`define DEPTH_MIN      5'h04
`define DEPTH_MAX      5'h13
`define DEPTH_RESET    5'h13
`define GAP_RESET      8'h01
`define NOISE_SEED     16'hace1
`define BINARY_TAPS    19'h5_b3d1
`define SAMPLES_PER_MS 16'h0010

`endif

// ---- rtl/excitation_mode_watchdog.v ----
`timescale 1ns/1ps
`default_nettype none
`include "excitation_defines.vh"

module excitation_mode_watchdog #(
	parameter [15:0] SAMPLES_PER_MS = `SAMPLES_PER_MS
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [31:0] reg_rdata,
	output reg         reg_rdata_valid,
	// Drive context
	input  wire        sample_tick,
	input  wire        link_up,
	// Sample stream to the control loop
	output wire        out_valid,
	input  wire        out_ready,
	output wire [15:0] out_sample,
	output wire [1:0]  out_target,
	output wire        in_ready
);

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	reg  [1:0]  excitation_injection_point;
	reg  [2:0]  waveform_mode;
	reg  [31:0] excitation_watchdog_period;
	reg  [4:0]  sequence_length_exponent;
	reg  [7:0]  excitation_sample_gap;
	reg  [14:0] current_excitation_amplitude;
	reg  [14:0] velocity_excitation_amplitude;
	reg  [15:0] ms_prescale;
	reg  [31:0] ms_elapsed;

	wire        wr_point  = reg_write && (reg_addr == `OFS_INJECTION_POINT);
	wire        wr_mode   = reg_write && (reg_addr == `OFS_WAVEFORM_MODE);
	wire        mode_ok   = (reg_wdata[31:3] == 29'h0) && (reg_wdata[2:0] <= `MODE_OFFSET);
	wire        mode_arm  = wr_mode && mode_ok && (reg_wdata[2:0] != `MODE_OFF);
	wire        ms_tick   = sample_tick && (ms_prescale == SAMPLES_PER_MS - 16'h0001);
	wire        wd_expire = ms_tick && (excitation_watchdog_period != 32'h0) &&
	                        (ms_elapsed + 32'h1 >= excitation_watchdog_period);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			excitation_injection_point <= `POINT_NONE;
		end else if (wr_point && reg_wdata <= {30'h0, `POINT_VELOCITY}) begin // [R14]
			excitation_injection_point <= reg_wdata[1:0]; // [R1]
		end
	end

	// Link loss beats a host write, which in turn beats the watchdog
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waveform_mode <= `MODE_OFF;
		end else if (!link_up) begin
			waveform_mode <= `MODE_OFF; // [R3]
		end else if (wr_mode && mode_ok) begin
			waveform_mode <= reg_wdata[2:0]; // [R2] [R14]
		end else if (wd_expire && waveform_mode != `MODE_OFF) begin
			waveform_mode <= `MODE_OFF; // [R6]
		end
	end

	// Limit is inclusive, so the largest period still arms the watchdog
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			excitation_watchdog_period <= `PERIOD_RESET;
		end else if (reg_write && reg_addr == `OFS_WATCHDOG_PERIOD && reg_wdata <= `PERIOD_MAX) begin
			excitation_watchdog_period <= reg_wdata; // [R12]
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sequence_length_exponent <= `DEPTH_RESET;
		end else if (reg_write && reg_addr == `OFS_SEQ_DEPTH && reg_wdata[31:5] == 27'h0 &&
		             reg_wdata[4:0] >= `DEPTH_MIN && reg_wdata[4:0] <= `DEPTH_MAX) begin
			sequence_length_exponent <= reg_wdata[4:0]; // [R13]
		end
	end

	// A zero gap would freeze the sequence, so it is refused
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			excitation_sample_gap <= `GAP_RESET;
		end else if (reg_write && reg_addr == `OFS_SAMPLE_GAP && reg_wdata[7:0] != 8'h00) begin
			excitation_sample_gap <= reg_wdata[7:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			current_excitation_amplitude <= `AMP_RESET;
		end else if (reg_write && reg_addr == `OFS_CURRENT_AMP) begin
			current_excitation_amplitude <= reg_wdata[14:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			velocity_excitation_amplitude <= `AMP_RESET;
		end else if (reg_write && reg_addr == `OFS_VELOCITY_AMP) begin
			velocity_excitation_amplitude <= reg_wdata[14:0];
		end
	end

	// ----------------------------------------------------------------
	// Millisecond watchdog
	// ----------------------------------------------------------------
	// Timer counts drive samples, so a stalled sample clock also stalls it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_prescale <= 16'h0000;
			ms_elapsed  <= 32'h0000_0000;
		end else if (mode_arm || waveform_mode == `MODE_OFF) begin
			ms_prescale <= 16'h0000; // [R7]
			ms_elapsed  <= 32'h0000_0000;
		end else if (sample_tick) begin
			if (ms_tick) begin
				ms_prescale <= 16'h0000; // [R15]
				if (excitation_watchdog_period != 32'h0) begin
					ms_elapsed <= ms_elapsed + 32'h1; // [R5]
				end
			end else begin
				ms_prescale <= ms_prescale + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read-back
	// ----------------------------------------------------------------
	reg  [31:0] next_rdata;

	// Unmapped offsets read as zero
	always @* begin
		case (reg_addr)
			`OFS_INJECTION_POINT: next_rdata = {30'h0, excitation_injection_point};
			`OFS_WAVEFORM_MODE:   next_rdata = {29'h0, waveform_mode};
			`OFS_WATCHDOG_PERIOD: next_rdata = excitation_watchdog_period;
			`OFS_SEQ_DEPTH:       next_rdata = {27'h0, sequence_length_exponent};
			`OFS_SAMPLE_GAP:      next_rdata = {24'h0, excitation_sample_gap};
			`OFS_CURRENT_AMP:     next_rdata = {17'h0, current_excitation_amplitude};
			`OFS_VELOCITY_AMP:    next_rdata = {17'h0, velocity_excitation_amplitude};
			default:              next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data holds until the next read, so a slow host may take it late
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata       <= 32'h0000_0000;
			reg_rdata_valid <= 1'b0;
		end else begin
			reg_rdata_valid <= reg_read;
			if (reg_read) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Waveform generation
	// ----------------------------------------------------------------
	reg  [18:0] binary_phase;
	reg  [4:0]  sine_phase;
	reg  [15:0] noise_lfsr;
	reg  [15:0] next_sample;
	reg  [2:0]  sine_index;
	reg  [7:0]  sine_mag;
	wire        push;

	function [7:0] quarter_sine;
		input [2:0] idx;
		begin
			case (idx)
				3'h0:    quarter_sine = 8'h19;
				3'h1:    quarter_sine = 8'h4a;
				3'h2:    quarter_sine = 8'h78;
				3'h3:    quarter_sine = 8'ha2;
				3'h4:    quarter_sine = 8'hc5;
				3'h5:    quarter_sine = 8'he1;
				3'h6:    quarter_sine = 8'hf4;
				default: quarter_sine = 8'hfe;
			endcase
		end
	endfunction

	wire [14:0] peak = (excitation_injection_point == `POINT_VELOCITY) ?
	                   velocity_excitation_amplitude : current_excitation_amplitude; // [R4]
	wire [18:0] depth_mask  = (19'h0_0001 << sequence_length_exponent) - 19'h0_0001;
	wire [18:0] phase_step  = binary_phase + {11'h0, excitation_sample_gap};
	wire        binary_sign = ^(binary_phase & `BINARY_TAPS);
	wire [15:0] peak_s      = {1'b0, peak};
	wire [22:0] sine_prod   = peak * sine_mag;
	wire [31:0] noise_prod  = $signed(noise_lfsr) * $signed(peak_s);
	wire [15:0] sine_scaled = {1'b0, sine_prod[22:8]};

	always @* begin
		sine_index  = sine_phase[3] ? ~sine_phase[2:0] : sine_phase[2:0];
		sine_mag    = quarter_sine(sine_index);
		next_sample = 16'h0000;
		if (excitation_injection_point != `POINT_NONE) begin
			case (waveform_mode)
				`MODE_BINARY: next_sample = binary_sign ? (16'h0000 - peak_s) : peak_s; // [R8]
				`MODE_SINE:   next_sample = sine_phase[4] ? (16'h0000 - sine_scaled) : sine_scaled;
				`MODE_NOISE:  next_sample = noise_prod[30:15]; // [R10]
				`MODE_OFFSET: next_sample = {1'b0, current_excitation_amplitude}; // [R11]
				default:      next_sample = 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Generator state
	// ----------------------------------------------------------------
	// Generator only advances on an accepted sample so a stall skips nothing
	// Phase wraps at two to the depth, so depth and gap together set the repeat length
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			binary_phase <= 19'h0_0000;
		end else if (push) begin
			binary_phase <= phase_step & depth_mask; // [R9]
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sine_phase <= 5'h00;
		end else if (push) begin
			sine_phase <= sine_phase + excitation_sample_gap[4:0];
		end
	end

	// Seed must be nonzero or the shift register locks up
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			noise_lfsr <= `NOISE_SEED;
		end else if (push) begin
			noise_lfsr <= {noise_lfsr[14:0],
			               noise_lfsr[15] ^ noise_lfsr[13] ^ noise_lfsr[12] ^ noise_lfsr[10]};
		end
	end

	// ----------------------------------------------------------------
	// Two-entry output buffer
	// ----------------------------------------------------------------
	reg         wr_ptr;
	reg         rd_ptr;
	reg  [1:0]  count;
	wire        pop = out_valid && out_ready;
	genvar      e;

	// One register per entry; only the slot under the write pointer loads
	generate
		for (e = 0; e < 2; e = e + 1) begin : slot
			reg  [17:0] data;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					data <= 18'h0_0000;
				end else if (push && wr_ptr == (e == 1)) begin
					data <= {excitation_injection_point, next_sample};
				end
			end
		end
	endgenerate

	// Sample and target share one slot so they can never part company
	assign in_ready   = (count != 2'h2);
	assign push       = sample_tick && in_ready; // [R15]
	assign out_valid  = (count != 2'h0);
	assign out_sample = rd_ptr ? slot[1].data[15:0] : slot[0].data[15:0];
	assign out_target = rd_ptr ? slot[1].data[17:16] : slot[0].data[17:16];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push && !pop) begin
				count <= count + 2'h1;
			end else if (pop && !push) begin
				count <= count - 2'h1;
			end
		end
	end

endmodule

`default_nettype wire
